// [logic/diag_log_pkg.sv]
// constants and types shared by the diagnostic event log
package diag_log_pkg;
  // ----------------------------------------
  // sizes
  // ----------------------------------------
  localparam int DEPTH      = 40;
  localparam int FAULT_W    = 16;
  localparam int TIME_W     = 32;
  localparam int INDEX_W    = 6;
  localparam int CHAN_W     = 4;
  // ----------------------------------------
  // setting codes and reset values
  // ----------------------------------------
  localparam logic [1:0] MODE_STOP_RETAIN = 2'h0;
  localparam logic [1:0] MODE_STOP        = 2'h1;
  localparam logic [1:0] MODE_CONT_RETAIN = 2'h2;
  localparam logic [1:0] MODE_CONT        = 2'h3;
  localparam int         MODE_CONT_BIT    = 1;
  localparam int         MODE_VOLATILE_BIT = 0;
  localparam logic       FILTER_BOTH      = 1'h0;
  localparam logic       FILTER_COMING    = 1'h1;
  localparam logic [1:0] MODE_RESET       = MODE_STOP_RETAIN;
  localparam logic       FILTER_RESET     = FILTER_BOTH;
  // ----------------------------------------
  // setting writer sources
  // ----------------------------------------
  typedef enum logic [1:0] {
    SRC_BUS      = 2'h1,
    SRC_HANDHELD = 2'h2
  } source_type;
endpackage

// [logic/diag_slot_index.sv]
// slot index arithmetic: wrapping increment of a ring pointer
`timescale 1ns/1ps
module diag_slot_index #(
  parameter int DEPTH   = 40,
  parameter int INDEX_W = 6
) (
  input  wire logic [INDEX_W-1:0] index,
  output logic      [INDEX_W-1:0] next_index
);
  always_comb begin
    if (index == INDEX_W'(DEPTH - 1)) begin
      next_index = '0;
    end else begin
      next_index = index + INDEX_W'(1);
    end
  end
endmodule

// [logic/diag_event_log.sv]
// diagnostic event log: setting store, ring buffer and oldest-first readout
//
// Operation
// R1: hold at most forty diagnostic records
// R2: stop mode keeps first forty, drops rest
// R3: continuous mode overwrites oldest after forty
// R4: retained variant survives power loss
// R5: volatile variant clears records on power loss
// R6: both-edge filter logs appear and clear
// R7: coming-only filter logs appearance only
// R8: settings come from bus or handheld
// R9: module parameters target module or channel
// R10: bus writes settings despite handheld lock
// R11: wrapping write index, oldest first readout
`timescale 1ns/1ps
module diag_event_log #(
  parameter int DEPTH_P = diag_log_pkg::DEPTH
) (
  input  wire logic                                clk,
  input  wire logic                                resetn,
  input  wire logic                                power_lost,
  input  wire logic                                event_valid,
  input  wire logic                                event_coming,
  input  wire logic [diag_log_pkg::FAULT_W-1:0]    event_fault,
  input  wire logic [diag_log_pkg::TIME_W-1:0]     event_time,
  input  wire logic                                set_valid,
  input  wire diag_log_pkg::source_type            set_source,
  input  wire logic [1:0]                          set_mode,
  input  wire logic                                set_filter,
  input  wire logic                                handheld_lock,
  input  wire logic                                param_valid,
  input  wire logic                                param_whole,
  input  wire logic [diag_log_pkg::CHAN_W-1:0]     param_channel,
  input  wire logic [7:0]                          param_value,
  input  wire logic                                read_req,
  input  wire logic [diag_log_pkg::INDEX_W-1:0]    read_pos,
  output logic                                     read_valid,
  output logic      [diag_log_pkg::FAULT_W-1:0]    read_fault,
  output logic      [diag_log_pkg::TIME_W-1:0]     read_time,
  output logic                                     read_coming,
  output logic      [diag_log_pkg::INDEX_W-1:0]    count,
  output logic      [1:0]                          mode,
  output logic                                     filter,
  output logic      [7:0]                          module_param,
  output logic      [7:0]                          channel_param [1 << diag_log_pkg::CHAN_W]
);
  import diag_log_pkg::*;

  // ----------------------------------------
  // synchronised power-loss pin
  // ----------------------------------------
  logic power_meta;
  logic power_sync;
  logic power_prev;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      power_meta <= 1'b0;
      power_sync <= 1'b0;
      power_prev <= 1'b0;
    end else begin
      power_meta <= power_lost;
      power_sync <= power_meta;
      power_prev <= power_sync;
    end
  end

  logic power_drop;
  assign power_drop = power_sync & ~power_prev;

  // ----------------------------------------
  // settings
  // ----------------------------------------
  logic [1:0] next_mode;
  logic       next_filter;
  logic [7:0] next_module_param;
  logic [7:0] next_channel_param [1 << CHAN_W];
  logic       setting_ok;
  logic       param_ok;

  always_comb begin
    // bus may always write the log settings; lock only blocks module parameters
    setting_ok = set_valid && (set_source == SRC_BUS || set_source == SRC_HANDHELD); // [R8] [R10]
    param_ok   = param_valid && !handheld_lock;
    next_mode   = mode;
    next_filter = filter;
    next_module_param  = module_param;
    next_channel_param = channel_param;
    if (setting_ok) begin
      next_mode   = set_mode;
      next_filter = set_filter;
    end
    if (param_ok) begin
      if (param_whole) begin
        next_module_param = param_value; // [R9]
      end else begin
        next_channel_param[param_channel] = param_value; // [R9]
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mode          <= MODE_RESET;
      filter        <= FILTER_RESET;
      module_param  <= 8'h00;
      channel_param <= '{default: 8'h00};
    end else begin
      mode          <= next_mode;
      filter        <= next_filter;
      module_param  <= next_module_param;
      channel_param <= next_channel_param;
    end
  end

  // ----------------------------------------
  // ring buffer
  // ----------------------------------------
  // record storage stays as is under reset; only pointers are cleared by a volatile loss
  logic [FAULT_W-1:0] mem_fault  [DEPTH_P];
  logic [TIME_W-1:0]  mem_time   [DEPTH_P];
  logic               mem_coming [DEPTH_P];
  logic [INDEX_W-1:0] wr_index;
  logic [INDEX_W-1:0] wr_index_inc;
  logic [INDEX_W-1:0] next_wr_index;
  logic [INDEX_W-1:0] next_count;
  logic               do_store;
  logic               full;
  logic               log_it;

  diag_slot_index #(.DEPTH(DEPTH_P), .INDEX_W(INDEX_W)) u_wrap (
    .index      (wr_index),
    .next_index (wr_index_inc)
  );

  always_comb begin
    full     = (count == INDEX_W'(DEPTH_P)); // [R1]
    log_it   = event_valid && (event_coming || filter == FILTER_BOTH); // [R6] [R7]
    do_store = log_it && (!full || mode[MODE_CONT_BIT]); // [R2] [R3]
    next_wr_index = wr_index;
    next_count    = count;
    if (power_drop && mode[MODE_VOLATILE_BIT]) begin
      next_wr_index = '0; // [R5]
      next_count    = '0; // [R5]
    end else if (do_store) begin
      next_wr_index = wr_index_inc; // [R11]
      if (!full) begin
        next_count = count + INDEX_W'(1);
      end
    end
  end

  // counters are kept across a retained power loss; resetn is the cold start
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_index <= '0;
      count    <= '0;
    end else begin
      wr_index <= next_wr_index; // [R4]
      count    <= next_count;
    end
  end

  always_ff @(posedge clk) begin
    if (do_store && !(power_drop && mode[MODE_VOLATILE_BIT])) begin
      mem_fault[wr_index]  <= event_fault;
      mem_time[wr_index]   <= event_time;
      mem_coming[wr_index] <= event_coming;
    end
  end

  // ----------------------------------------
  // oldest-first readout
  // ----------------------------------------
  logic [INDEX_W:0]   sum;
  logic [INDEX_W-1:0] slot;
  logic               next_read_valid;
  logic [FAULT_W-1:0] next_read_fault;
  logic [TIME_W-1:0]  next_read_time;
  logic               next_read_coming;

  always_comb begin
    // oldest sits at the write index once full, else at slot zero
    sum = full ? ({1'b0, wr_index} + {1'b0, read_pos}) : {1'b0, read_pos}; // [R11]
    if (sum >= (INDEX_W + 1)'(DEPTH_P)) begin
      slot = INDEX_W'(sum - (INDEX_W + 1)'(DEPTH_P));
    end else begin
      slot = sum[INDEX_W-1:0];
    end
    next_read_valid  = read_req && (read_pos < count);
    // data holds between answers so a slow reader may pick it up late
    next_read_fault  = read_fault;
    next_read_time   = read_time;
    next_read_coming = read_coming;
    if (next_read_valid) begin
      next_read_fault  = mem_fault[slot];
      next_read_time   = mem_time[slot];
      next_read_coming = mem_coming[slot];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      read_valid  <= 1'b0;
      read_fault  <= '0;
      read_time   <= '0;
      read_coming <= 1'b0;
    end else begin
      read_valid  <= next_read_valid;
      read_fault  <= next_read_fault;
      read_time   <= next_read_time;
      read_coming <= next_read_coming;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_count_bound: assert property (@(posedge clk) disable iff (!resetn) // [R1]
    count <= INDEX_W'(DEPTH_P)) else $error("record count above depth");
  a_stop_full: assert property (@(posedge clk) disable iff (!resetn) // [R2]
    (full && !mode[MODE_CONT_BIT] && !power_drop) |=> $stable(wr_index))
    else $error("stop mode stored past full");
  a_cont_wrap: assert property (@(posedge clk) disable iff (!resetn) // [R3]
    (full && mode[MODE_CONT_BIT] && log_it && !power_drop) |=> full && wr_index != $past(wr_index))
    else $error("continuous mode did not advance");
  a_retain_keep: assert property (@(posedge clk) disable iff (!resetn) // [R4]
    (power_drop && !mode[MODE_VOLATILE_BIT] && !event_valid) |=> count == $past(count))
    else $error("retained log lost records");
  a_volatile_clr: assert property (@(posedge clk) disable iff (!resetn) // [R5]
    (power_drop && mode[MODE_VOLATILE_BIT]) |=> count == '0)
    else $error("volatile log not cleared");
  a_going_drop: assert property (@(posedge clk) disable iff (!resetn) // [R7]
    (event_valid && !event_coming && filter == FILTER_COMING && !power_drop)
      |=> count == $past(count) && wr_index == $past(wr_index))
    else $error("going event logged in coming-only mode");
  a_going_keep: assert property (@(posedge clk) disable iff (!resetn) // [R6]
    (event_valid && !event_coming && filter == FILTER_BOTH && !full && !power_drop)
      |=> count == $past(count) + INDEX_W'(1))
    else $error("going event not logged");
  a_bus_locked: assert property (@(posedge clk) disable iff (!resetn) // [R10]
    (set_valid && set_source == SRC_BUS && handheld_lock) |=> mode == $past(set_mode))
    else $error("bus setting refused under lock");
  a_read_latency: assert property (@(posedge clk) disable iff (!resetn) // [R11]
    (read_req && read_pos < count) |=> read_valid)
    else $error("read answer missing");

  c_fill: cover property (@(posedge clk) disable iff (!resetn) full);
  c_wrap: cover property (@(posedge clk) disable iff (!resetn) full && do_store);
  c_clear: cover property (@(posedge clk) disable iff (!resetn) power_drop);
  c_read: cover property (@(posedge clk) disable iff (!resetn) read_valid && full);
endmodule

// [sim/setting_writer.sv]
// setting writer model: field bus master or handheld writing log settings
`timescale 1ns/1ps
module setting_writer (
  input  wire logic                 clk,
  output logic                      set_valid,
  output diag_log_pkg::source_type  set_source,
  output logic [1:0]                set_mode,
  output logic                      set_filter
);
  import diag_log_pkg::*;
  initial begin
    set_valid  = 1'b0;
    set_source = SRC_BUS;
    set_mode   = 2'h0;
    set_filter = 1'b0;
  end
  // ----------------------------------------
  // one write; gap idle cycles model a slow writer
  // ----------------------------------------
  task automatic write(input logic [1:0] src, input logic [1:0] m, input logic f, input int gap);
    repeat (gap) @(posedge clk);
    @(posedge clk);
    set_valid  <= 1'b1;
    set_source <= source_type'(src);
    set_mode   <= m;
    set_filter <= f;
    @(posedge clk);
    set_valid  <= 1'b0;
    // released lines must not keep showing the last value
    set_mode   <= ~m;
    set_filter <= ~f;
    set_source <= source_type'(~src);
  endtask
endmodule

// [sim/tb_top.sv]
// testbench for the diagnostic event log
`timescale 1ns/1ps
module tb_top;
  import diag_log_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic power_lost = 1'b0;
  logic event_valid = 1'b0;
  logic event_coming = 1'b0;
  logic [FAULT_W-1:0] event_fault = '0;
  logic [TIME_W-1:0] event_time = '0;
  logic set_valid, set_filter, handheld_lock = 1'b0;
  source_type set_source;
  logic [1:0] set_mode, mode;
  logic param_valid = 1'b0;
  logic param_whole = 1'b0;
  logic [CHAN_W-1:0] param_channel = '0;
  logic [7:0] param_value = '0;
  logic read_req = 1'b0;
  logic [INDEX_W-1:0] read_pos = '0;
  logic read_valid, read_coming, filter;
  logic [FAULT_W-1:0] read_fault;
  logic [TIME_W-1:0] read_time;
  logic [INDEX_W-1:0] count;
  logic [7:0] module_param;
  logic [7:0] chan_p [1 << CHAN_W];
  logic [48:0] recs[$];
  logic [48:0] exp_q[$];
  logic [1:0] cur_mode = MODE_RESET;
  logic cur_filt = FILTER_RESET;
  int fail_count = 0;
  int samples_checked = 0;
  int seed = 77;
  always #2.5 clk = ~clk;
  setting_writer u_host (.clk(clk), .set_valid(set_valid), .set_source(set_source),
    .set_mode(set_mode), .set_filter(set_filter));
  diag_event_log u_dut (.clk(clk), .resetn(resetn), .power_lost(power_lost),
    .event_valid(event_valid), .event_coming(event_coming), .event_fault(event_fault),
    .event_time(event_time), .set_valid(set_valid), .set_source(set_source),
    .set_mode(set_mode), .set_filter(set_filter), .handheld_lock(handheld_lock),
    .param_valid(param_valid), .param_whole(param_whole), .param_channel(param_channel),
    .param_value(param_value), .read_req(read_req), .read_pos(read_pos),
    .read_valid(read_valid), .read_fault(read_fault), .read_time(read_time),
    .read_coming(read_coming), .count(count), .mode(mode), .filter(filter),
    .module_param(module_param), .channel_param(chan_p));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [48:0] got, input logic [48:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // reference store follows mode and filter as the log should
  task automatic evt(input logic coming);
    logic [47:0] v;
    v = {16'($random(seed)), 32'($random(seed))};
    @(posedge clk);
    event_valid  <= 1'b1;
    event_coming <= coming;
    event_fault  <= v[47:32];
    event_time   <= v[31:0];
    if (coming || cur_filt == FILTER_BOTH) begin
      if (recs.size() == DEPTH && cur_mode[MODE_CONT_BIT]) void'(recs.pop_front());
      if (recs.size() < DEPTH) recs.push_back({coming, v});
    end
  endtask
  task automatic burst(input int n);
    for (int i = 0; i < n; i++) evt(1'($random(seed)));
    @(posedge clk);
    event_valid <= 1'b0;
    event_fault <= ~event_fault;
    event_time  <= ~event_time;
    settle(1);
    chk(49'(count), 49'(recs.size()));
  endtask
  // one read past the end checks that no answer comes
  task automatic read_all();
    for (int i = 0; i <= recs.size(); i++) begin
      @(posedge clk);
      read_req <= 1'b1;
      read_pos <= INDEX_W'(i);
      if (i < recs.size()) exp_q.push_back(recs[i]);
    end
    @(posedge clk);
    read_req <= 1'b0;
    read_pos <= ~read_pos;
    settle(3);
    chk(49'(exp_q.size()), 49'd0);
  endtask
  task automatic setting(input logic [1:0] src, input logic [1:0] m, input logic f, input int gap);
    u_host.write(src, m, f, gap);
    if (src == 2'h1 || src == 2'h2) begin
      cur_mode = m;
      cur_filt = f;
    end
    settle(1);
    chk(49'({mode, filter}), 49'({cur_mode, cur_filt}));
  endtask
  task automatic power_cut();
    @(posedge clk);
    power_lost <= 1'b1;
    if (cur_mode[MODE_VOLATILE_BIT]) recs.delete();
    settle(6);
    chk(49'(count), 49'(recs.size()));
    @(posedge clk);
    power_lost <= 1'b0;
  endtask
  task automatic param(input logic whole, input logic [3:0] ch, input logic [7:0] v,
                       input logic lk);
    @(posedge clk);
    handheld_lock <= lk;
    param_valid   <= 1'b1;
    param_whole   <= whole;
    param_channel <= ch;
    param_value   <= v;
    @(posedge clk);
    param_valid <= 1'b0;
    param_value <= ~v;
    settle(1);
  endtask
  task automatic finish_test();
    if (fail_count == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // monitor: oldest note against each answer
  // ----------------------------------------
  always @(posedge clk) begin
    if (read_valid === 1'b1) begin
      if (exp_q.size() == 0) chk(49'd1, 49'd0); // answer without request
      else chk({read_coming, read_fault, read_time}, exp_q.pop_front());
    end
  end
  // run needs well under 2000 cycles; ten times that is a hang
  initial begin
    #100000;
    fail_count++;
    finish_test();
  end
  initial begin
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    settle(1);
    chk(49'({count, mode, filter}), 49'({6'h0, MODE_RESET, FILTER_RESET}));
    param(1'b1, 4'h0, 8'h5a, 1'b1);
    chk(49'(module_param), 49'h0); // locked write ignored
    setting(2'h1, MODE_STOP, FILTER_BOTH, 0); // while locked
    burst(42); // full then drops
    read_all(); // first forty kept
    power_cut(); // volatile clears
    setting(2'h2, MODE_CONT_RETAIN, FILTER_COMING, 3); // slow handheld
    setting(2'h0, MODE_CONT, FILTER_BOTH, 0); // unknown source ignored
    burst(95); // going dropped, ring wraps
    read_all(); // oldest first after wrap
    power_cut(); // retained
    read_all(); // contents intact
    setting(2'h1, MODE_CONT, FILTER_BOTH, 0);
    burst(6); // going logged too
    read_all();
    power_cut();
    setting(2'h2, MODE_STOP_RETAIN, FILTER_BOTH, 1);
    burst(44);
    param(1'b1, 4'h0, 8'h5a, 1'b0);
    param(1'b0, 4'h3, 8'hc3, 1'b0);
    chk(49'({module_param, chan_p[3], chan_p[2]}), 49'h5a_c300);
    finish_test();
  end
endmodule
